// ==== verilog/sflash_pkg.sv ====
// Purpose: Shared constants for the serial flash host-interface front end
// Assumes: Single 200 MHz system clock samples all serial pins
// Notes:   Instruction codes and timing counts live here only
package sflash_pkg;
    localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
    localparam logic [7:0] OP_QUAD_WORD  = 8'hE7;
    localparam logic [7:0] OP_QUAD_OCT   = 8'hE3;
    localparam logic [7:0] OP_ENTER_4W   = 8'h38;
    localparam logic [7:0] OP_EXIT_4W    = 8'hFF;
    localparam logic [7:0] OP_RST_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET      = 8'h99;
    localparam logic [7:0] OP_WREN       = 8'h06;
    localparam logic [7:0] OP_WREN_VOL   = 8'h50;
    // Bits per byte on one line, clocks per byte on four lines
    localparam logic [3:0] BITS_1W = 4'h8;
    localparam logic [3:0] BITS_4W = 4'h2;
    // Lane widths
    localparam logic [2:0] LANES_1 = 3'h1;
    localparam logic [2:0] LANES_2 = 3'h2;
    localparam logic [2:0] LANES_4 = 3'h4;
    // Line mode of the current transfer
    typedef enum logic [1:0] {
        LM_SINGLE = 2'b00,
        LM_DUAL   = 2'b01,
        LM_QUAD   = 2'b11
    } line_mode_t;
endpackage

// ==== verilog/pin_sync.sv ====
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins
// Assumes: Inputs come from outside the mclk domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] rst_val,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Next values; reset loads the idle level of each pin
    always_comb begin
        meta_d = sys_rst ? rst_val : async_in;
        sync_d = sys_rst ? rst_val : meta_q;
    end

    always_ff @(posedge mclk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;
endmodule

// ==== verilog/sflash_front_end.sv ====
// Overview of operation
// (R1) Works with clock modes 0 and 3 only
// (R2) Capture on rising, drive on falling edge
// (R3) Master parks clock per its mode
// (R4) Cycles counted falling edge to falling edge
// (R5) Dual reads use line0 and line1 bidirectionally
// (R6) Quad reads 6B EB E7 E3 use four lines
// (R7) Quad uses protect and pause pins as lines
// (R8) Quad reads need four_line_enable_bit set
// (R9) 38h enters, FFh exits four-wire command mode
// (R10) Four-wire mode takes opcode in two clocks
// (R11) Exactly one command mode active
// (R12) Power-up and 99h reset select standard mode
// (R13) Four-wire entry needs four_line_enable_bit
// (R14) Software reset is 66h then 99h
// (R15) 06h enables NV write; 50h volatile copy
// (R16) Pause only in standard/dual, while selected
// (R17) Pause entry at low clock or next fall
// (R18) Pause exit at low clock or next fall
// (R19) Paused: outputs float, inputs ignored
// (R20) Pause keeps interface state intact
// (R21) Master keeps select low during pause
// (R22) pause_or_reset_pick selects line3 role
// (R23) four_line_enable_bit makes line3 data only
// (R24) Quad and entry ignored without enable bit
//
// Purpose: Serial front end: opcode capture, lane control, pause, resets
// Assumes: sclk well below mclk/4; all pins synchronised by two flops
// Notes:   Outgoing data comes from the core as tx_data, one lane set per fall
`timescale 1ns/1ps
module sflash_front_end
    import sflash_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       sclk,
    input  wire logic       select_low_n,
    input  wire logic [3:0] line_in,
    input  wire logic       four_line_enable_bit,
    input  wire logic       pause_or_reset_pick,
    input  wire logic       read_phase,
    input  wire logic [3:0] tx_data,
    output logic      [3:0] line_out,
    output logic      [3:0] line_oe,
    output logic      [7:0] opcode,
    output logic            opcode_valid,
    output logic            four_wire_mode,
    output logic [1:0]      line_mode,
    output logic            paused,
    output logic            soft_reset_pulse,
    output logic            hw_reset,
    output logic            wren_nv,
    output logic            wren_vol,
    output logic [3:0]      rx_nibble,
    output logic            rx_valid
);
    // Synchronised pins: sclk, select, four data lines
    logic [5:0] pins_s;
    pin_sync #(.WIDTH(6)) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in ({sclk, select_low_n, line_in}),
        .rst_val  (6'h18),
        .sync_out (pins_s)
    );
    logic       sclk_s;
    logic       sel_n_s;
    logic [3:0] din_s;
    assign sclk_s  = pins_s[5];
    assign sel_n_s = pins_s[4];
    assign din_s   = pins_s[3:0];

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_OPCODE = 2'b01,
        ST_DATA   = 2'b11
    } fe_state_t;

    fe_state_t  state_q, state_d;
    logic       sclk_q, sclk_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] opcode_q, opcode_d;
    logic       opv_q, opv_d;
    logic       fw_q, fw_d;
    logic [1:0] lm_q, lm_d;
    logic       rst_arm_q, rst_arm_d;
    logic       srst_q, srst_d;
    logic       pause_q, pause_d;
    logic       hwr_q, hwr_d;
    logic       wnv_q, wnv_d;
    logic       wvol_q, wvol_d;
    logic [3:0] lout_q, lout_d;
    logic [3:0] loe_q, loe_d;
    logic [3:0] rxn_q, rxn_d;
    logic       rxv_q, rxv_d;

    // Edges of the sampled serial clock
    logic rise, fall, pause_req, pause_ok;
    logic [3:0] new_cnt;
    logic [7:0] new_byte;
    logic       quad_op;
    assign rise = sclk_s & ~sclk_q; // R1 R2
    assign fall = ~sclk_s & sclk_q; // R2 R4
    // line3 acts as pause pin only in pause role and not quad-enabled
    assign pause_ok = ~four_line_enable_bit & ~pause_or_reset_pick; // R22 R23
    assign pause_req = pause_ok & ~din_s[3] & ~sel_n_s
                     & (lm_q != LM_QUAD) & ~fw_q; // R16

    // Main next-state logic
    always_comb begin
        state_d   = state_q;
        sclk_d    = sclk_s;
        shift_d   = shift_q;
        cnt_d     = cnt_q;
        opcode_d  = opcode_q;
        opv_d     = 1'b0;
        fw_d      = fw_q;
        lm_d      = lm_q;
        rst_arm_d = rst_arm_q;
        srst_d    = 1'b0;
        pause_d   = pause_q;
        hwr_d     = pause_or_reset_pick & ~four_line_enable_bit
                  & ~din_s[3]; // R22 R23
        wnv_d     = 1'b0;
        wvol_d    = 1'b0;
        lout_d    = lout_q;
        loe_d     = loe_q;
        rxn_d     = rxn_q;
        rxv_d     = 1'b0;
        new_cnt   = cnt_q;
        new_byte  = shift_q;
        quad_op   = 1'b0;
        // Pause changes state only while clock is low or on deselect
        if (~sclk_s) begin
            pause_d = pause_req; // R17 R18
        end
        if (sel_n_s) begin
            // Deselect resets the interface, even mid-pause
            state_d = ST_IDLE; // R21
            pause_d = 1'b0;
            cnt_d   = 4'h0;
            loe_d   = 4'h0;
            lm_d    = LM_SINGLE;
        end else if (pause_q) begin
            // Everything held; outputs floated
            loe_d = 4'h0; // R19 R20
        end else begin
            if (state_q == ST_IDLE) begin
                state_d = ST_OPCODE;
                cnt_d   = 4'h0;
            end
            if (rise && state_q != ST_IDLE) begin
                if (state_q == ST_OPCODE && fw_q) begin
                    new_byte = {shift_q[3:0], din_s}; // R10
                    new_cnt  = cnt_q + 4'h1;
                end else if (state_q == ST_OPCODE) begin
                    new_byte = {shift_q[6:0], din_s[0]};
                    new_cnt  = cnt_q + 4'h1;
                end else begin
                    rxv_d = 1'b1; // R5 R6
                    case (line_mode_t'(lm_q))
                        LM_QUAD: rxn_d = din_s; // R7
                        LM_DUAL: rxn_d = {2'b00, din_s[1:0]};
                        default: rxn_d = {3'b000, din_s[0]};
                    endcase
                end
                shift_d = new_byte;
                cnt_d   = new_cnt;
                if (state_q == ST_OPCODE
                    && new_cnt == (fw_q ? BITS_4W : BITS_1W)) begin
                    state_d  = ST_DATA;
                    opcode_d = new_byte;
                    opv_d    = 1'b1;
                    quad_op  = (new_byte == OP_QUAD_OUT)
                             | (new_byte == OP_QUAD_IO)
                             | (new_byte == OP_QUAD_WORD)
                             | (new_byte == OP_QUAD_OCT);
                    if (fw_q) begin
                        lm_d = LM_QUAD;
                    end else if (quad_op) begin
                        // Quad needs enable bit; else stay single
                        lm_d = four_line_enable_bit ? LM_QUAD
                                                    : LM_SINGLE; // R8 R24
                    end else if (new_byte == OP_DUAL_OUT
                                 || new_byte == OP_DUAL_IO) begin
                        lm_d = LM_DUAL; // R5
                    end
                    // Mode flag is one bit, so modes exclude each other
                    if (new_byte == OP_ENTER_4W && four_line_enable_bit) begin
                        fw_d = 1'b1; // R9 R11 R13 R24
                    end else if (new_byte == OP_EXIT_4W && fw_q) begin
                        fw_d = 1'b0; // R9 R11
                    end
                    if (new_byte == OP_RESET && rst_arm_q) begin
                        fw_d   = 1'b0; // R12 R14
                        srst_d = 1'b1;
                    end
                    rst_arm_d = (new_byte == OP_RST_ENABLE); // R14
                    wnv_d  = (new_byte == OP_WREN); // R15
                    wvol_d = (new_byte == OP_WREN_VOL); // R15
                end
            end
            // Drive outgoing bits on falling edge of read phase
            if (fall && state_q == ST_DATA) begin
                if (read_phase) begin
                    case (line_mode_t'(lm_q))
                        LM_QUAD: begin
                            lout_d = tx_data;
                            loe_d  = 4'hF; // R6 R7
                        end
                        LM_DUAL: begin
                            lout_d = {2'b00, tx_data[1:0]};
                            loe_d  = 4'h3; // R5
                        end
                        default: begin
                            lout_d = {2'b00, tx_data[0], 1'b0};
                            loe_d  = 4'h2; // R2
                        end
                    endcase
                end else begin
                    loe_d = 4'h0;
                end
            end
        end
    end

    // Register stage; reset selects standard mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q   <= ST_IDLE;
            sclk_q    <= 1'b0;
            shift_q   <= 8'h00;
            cnt_q     <= 4'h0;
            opcode_q  <= 8'h00;
            opv_q     <= 1'b0;
            fw_q      <= 1'b0; // R12
            lm_q      <= LM_SINGLE;
            rst_arm_q <= 1'b0;
            srst_q    <= 1'b0;
            pause_q   <= 1'b0;
            hwr_q     <= 1'b0;
            wnv_q     <= 1'b0;
            wvol_q    <= 1'b0;
            lout_q    <= 4'h0;
            loe_q     <= 4'h0;
            rxn_q     <= 4'h0;
            rxv_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            sclk_q    <= sclk_d;
            shift_q   <= shift_d;
            cnt_q     <= cnt_d;
            opcode_q  <= opcode_d;
            opv_q     <= opv_d;
            fw_q      <= fw_d;
            lm_q      <= lm_d;
            rst_arm_q <= rst_arm_d;
            srst_q    <= srst_d;
            pause_q   <= pause_d;
            hwr_q     <= hwr_d;
            wnv_q     <= wnv_d;
            wvol_q    <= wvol_d;
            lout_q    <= lout_d;
            loe_q     <= loe_d;
            rxn_q     <= rxn_d;
            rxv_q     <= rxv_d;
        end
    end

    assign line_out         = lout_q;
    assign line_oe          = loe_q;
    assign opcode           = opcode_q;
    assign opcode_valid     = opv_q;
    assign four_wire_mode   = fw_q;
    assign line_mode        = lm_q;
    assign paused           = pause_q;
    assign soft_reset_pulse = srst_q;
    assign hw_reset         = hwr_q;
    assign wren_nv          = wnv_q;
    assign wren_vol         = wvol_q;
    assign rx_nibble        = rxn_q;
    assign rx_valid         = rxv_q;

    // Checks
    a_pause_float: assert property (@(posedge mclk) disable iff (sys_rst)
        pause_q |=> (loe_q == 4'h0)) // R19
        else $error("outputs driven while paused");
    a_quad_needs_en: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(fw_q) |-> $past(four_line_enable_bit)) // R13
        else $error("four-wire entry without enable");
    a_reset_std: assert property (@(posedge mclk) disable iff (sys_rst)
        srst_q |-> ~fw_q) // R12
        else $error("soft reset left four-wire mode");
    a_reset_pair: assert property (@(posedge mclk) disable iff (sys_rst)
        srst_q |-> $past(rst_arm_q)) // R14
        else $error("reset without enable");
    a_pause_no_quad: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(pause_q) |-> $past(lm_q) != LM_QUAD && ~$past(fw_q)) // R16
        else $error("pause during quad");
    a_pause_low_clk: assert property (@(posedge mclk) disable iff (sys_rst)
        $changed(pause_q) && ~$past(sel_n_s) |-> ~$past(sclk_s)) // R17 R18
        else $error("pause changed with clock high");
    a_four_w_lanes: assert property (@(posedge mclk) disable iff (sys_rst)
        opv_q && $past(fw_q) |-> lm_q == LM_QUAD) // R10
        else $error("four-wire opcode not quad");
    a_quad_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(loe_q == 4'hF) |-> lm_q == LM_QUAD) // R8
        else $error("four lanes driven outside quad");
    c_enter_4w: cover property (@(posedge mclk) $rose(fw_q));
    c_pause: cover property (@(posedge mclk) $rose(pause_q));
    c_srst: cover property (@(posedge mclk) srst_q);
    c_dual: cover property (@(posedge mclk) loe_q == 4'h3);
endmodule

// ==== tb/spi_master.sv ====
// Purpose: Behavioural SPI bus master for the flash front end pins
// Assumes: Serial clock period 48 ns, phase unrelated to mclk
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/1ps
module spi_master (
    output logic       sclk,
    output logic       select_low_n,
    output logic [3:0] drv
);
    localparam int HALF = 24;
    logic cpol;

    // Idle bus: deselected, clock parked, pause pin high
    initial begin
        cpol = 1'b0;
        sclk = 1'b0;
        select_low_n = 1'b1;
        drv = 4'hF;
    end

    // Clock parks at the mode's idle level between frames and after each shift
    task automatic set_mode(input logic pol);
        cpol = pol;
        sclk = pol;
        #HALF;
    endtask

    // Select stays low through any pause, else the interface resets
    task automatic select();
        select_low_n = 1'b0;
        #HALF;
    endtask

    task automatic deselect();
        sclk = cpol;
        #HALF;
        select_low_n = 1'b1;
        #(3 * HALF);
    endtask

    // n clocks of w bits each, MSB first; data changes while clock is low
    task automatic shift(input logic [7:0] v, input int n, input int w);
        logic [7:0] s;
        s = v;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            if (w == 4) drv = s[7:4];
            else drv[0] = s[7];
            s = (w == 4) ? {s[3:0], 4'h0} : {s[6:0], 1'b0};
            #HALF;
            sclk = 1'b1;
            #HALF;
        end
        if (!cpol) sclk = 1'b0;
        if (w == 4) drv = ~drv;
        else drv[0] = ~drv[0];
        #HALF;
    endtask

    task automatic set_pin3(input logic v);
        drv[3] = v;
        #HALF;
    endtask

    task automatic clk(input logic v);
        sclk = v;
        #HALF;
    endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the serial flash front end
// Assumes: Partner master drives the pins, bench drives the config levels
// Notes:   Strobes are counted so a task never misses a one-cycle pulse
`timescale 1ns/1ps
module testbench
    import sflash_pkg::*;
;
    logic       mclk;
    logic       sys_rst;
    logic       four_line_enable_bit;
    logic       pause_or_reset_pick;
    logic       read_phase;
    logic [3:0] tx_data;
    logic       sclk;
    logic       select_low_n;
    logic [3:0] drv;
    logic [3:0] line_in;
    logic [3:0] line_out;
    logic [3:0] line_oe;
    logic [3:0] rx_nibble;
    logic [7:0] opcode;
    logic [1:0] line_mode;
    logic       opcode_valid, four_wire_mode, paused, soft_reset_pulse;
    logic       hw_reset, wren_nv, wren_vol, rx_valid;
    int         errors = 0;
    int         compares = 0;
    int         n_op = 0, n_nv = 0, n_vol = 0, n_rst = 0, n_rx = 0;
    logic [7:0] ops [6] = '{OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT,
                            OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_OCT};

    // Clock generator, 5 ns period
    always #2.5 mclk = ~mclk;

    // Wire level: the device wins where it drives, else the master
    assign line_in = (line_oe & line_out) | (~line_oe & drv);

    sflash_front_end u_sflash_front_end (
        .mclk                 (mclk),
        .sys_rst              (sys_rst),
        .sclk                 (sclk),
        .select_low_n         (select_low_n),
        .line_in              (line_in),
        .four_line_enable_bit (four_line_enable_bit),
        .pause_or_reset_pick  (pause_or_reset_pick),
        .read_phase           (read_phase),
        .tx_data              (tx_data),
        .line_out             (line_out),
        .line_oe              (line_oe),
        .opcode               (opcode),
        .opcode_valid         (opcode_valid),
        .four_wire_mode       (four_wire_mode),
        .line_mode            (line_mode),
        .paused               (paused),
        .soft_reset_pulse     (soft_reset_pulse),
        .hw_reset             (hw_reset),
        .wren_nv              (wren_nv),
        .wren_vol             (wren_vol),
        .rx_nibble            (rx_nibble),
        .rx_valid             (rx_valid)
    );

    spi_master u_spi_master (
        .sclk         (sclk),
        .select_low_n (select_low_n),
        .drv          (drv)
    );

    // Strobe counters
    always @(posedge mclk) begin
        if (opcode_valid === 1'b1) n_op <= n_op + 1;
        if (wren_nv === 1'b1) n_nv <= n_nv + 1;
        if (wren_vol === 1'b1) n_vol <= n_vol + 1;
        if (soft_reset_pulse === 1'b1) n_rst <= n_rst + 1;
        if (rx_valid === 1'b1) n_rx <= n_rx + 1;
    end

    task automatic complete_run();
        $display("Compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Send n clocks and wait, bounded, for the opcode strobe
    task automatic send(input logic [7:0] v, input int n, input int w);
        int b;
        int k;
        b = n_op;
        k = 0;
        u_spi_master.shift(v, n, w);
        while (n_op == b && k < 40) begin
            @(posedge mclk);
            k++;
        end
        if (n_op == b) begin
            errors++;
            $display("BAD opcode_valid expected 1 seen 0");
            complete_run();
        end
    endtask

    task automatic cfg(input logic en, input logic pick);
        @(posedge mclk);
        four_line_enable_bit <= en;
        pause_or_reset_pick <= pick;
        settle(4);
    endtask

    // One device output clock with the core asking to drive; line0 is
    // high at the rise and the other lines idle high, so every lane
    // the device captures should read as one
    task automatic drive_clock(input logic [3:0] d);
        @(posedge mclk);
        read_phase <= 1'b1;
        tx_data <= d;
        u_spi_master.shift(8'h80, 1, 1);
        settle(4);
        read_phase <= 1'b0;
    endtask

    // Main sequence
    initial begin
        int b;
        int r;
        logic [3:0] oe;
        mclk = 1'b0;
        sys_rst <= 1'b1;
        four_line_enable_bit <= 1'b0;
        pause_or_reset_pick <= 1'b0;
        read_phase <= 1'b0;
        tx_data <= 4'h0;
        settle(5);
        sys_rst <= 1'b0;
        settle(4);
        check("four_wire_mode", 8'(four_wire_mode), 8'h00);
        check("line_mode", 8'(line_mode), 8'(LM_SINGLE));
        b = n_nv;
        u_spi_master.select();
        send(OP_WREN, 8, 1);
        check("opcode", opcode, OP_WREN);
        check("wren_nv", 8'(n_nv - b), 8'h01);
        drive_clock(4'h5);
        check("line_oe", 8'(line_oe), 8'h02);
        check("rx_nibble", 8'(rx_nibble), 8'h01);
        u_spi_master.deselect();
        // Clock parked high, then a pause that waits for the next fall
        u_spi_master.set_mode(1'b1);
        b = n_vol;
        u_spi_master.select();
        send(OP_WREN_VOL, 8, 1);
        check("opcode", opcode, OP_WREN_VOL);
        check("wren_vol", 8'(n_vol - b), 8'h01);
        u_spi_master.set_pin3(1'b0);
        settle(6);
        check("paused", 8'(paused), 8'h00);
        u_spi_master.clk(1'b0);
        settle(6);
        check("paused", 8'(paused), 8'h01);
        u_spi_master.set_pin3(1'b1);
        settle(6);
        check("paused", 8'(paused), 8'h00);
        u_spi_master.deselect();
        u_spi_master.set_mode(1'b0);
        // Pause in mid-opcode with the clock low, then resume
        b = n_op;
        u_spi_master.select();
        u_spi_master.shift(OP_WREN, 4, 1);
        u_spi_master.set_pin3(1'b0);
        settle(6);
        check("paused", 8'(paused), 8'h01);
        r = n_rx;
        drive_clock(4'hF);
        u_spi_master.shift(8'hFF, 3, 1);
        check("line_oe", 8'(line_oe), 8'h00);
        check("opcode_count", 8'(n_op - b), 8'h00);
        check("rx_count", 8'(n_rx - r), 8'h00);
        u_spi_master.set_pin3(1'b1);
        settle(6);
        check("paused", 8'(paused), 8'h00);
        send({OP_WREN[3:0], 4'h0}, 4, 1);
        check("opcode", opcode, OP_WREN);
        u_spi_master.deselect();
        // Quad and entry refused without the enable bit
        u_spi_master.select();
        send(OP_QUAD_OUT, 8, 1);
        check("line_mode", 8'(line_mode), 8'(LM_SINGLE));
        u_spi_master.deselect();
        u_spi_master.select();
        send(OP_ENTER_4W, 8, 1);
        u_spi_master.deselect();
        check("four_wire_mode", 8'(four_wire_mode), 8'h00);
        cfg(1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            oe = (i < 2) ? 4'h3 : 4'hF;
            u_spi_master.select();
            send(ops[i], 8, 1);
            check("line_mode", 8'(line_mode),
                  (i < 2) ? 8'(LM_DUAL) : 8'(LM_QUAD));
            r = n_rx;
            drive_clock(4'hA);
            check("line_oe", 8'(line_oe), 8'(oe));
            check("line_out", 8'(line_out & oe), 8'(4'hA & oe));
            check("rx_nibble", 8'(rx_nibble), 8'(oe));
            check("rx_count", 8'(n_rx - r), 8'h01);
            u_spi_master.set_pin3(1'b0);
            settle(6);
            check("paused", 8'(paused), 8'h00);
            u_spi_master.set_pin3(1'b1);
            u_spi_master.deselect();
        end
        // Line3 role: reset input only while the enable bit is clear
        cfg(1'b1, 1'b1);
        u_spi_master.set_pin3(1'b0);
        settle(6);
        check("hw_reset", 8'(hw_reset), 8'h00);
        cfg(1'b0, 1'b1);
        check("hw_reset", 8'(hw_reset), 8'h01);
        u_spi_master.set_pin3(1'b1);
        cfg(1'b1, 1'b0);
        check("hw_reset", 8'(hw_reset), 8'h00);
        // Four-wire mode: entry, reset pair on four lines, exit
        for (int j = 0; j < 2; j++) begin
            u_spi_master.select();
            send(OP_ENTER_4W, 8, 1);
            u_spi_master.deselect();
            check("four_wire_mode", 8'(four_wire_mode), 8'h01);
            b = n_rst;
            u_spi_master.select();
            send(j ? OP_EXIT_4W : OP_RST_ENABLE, 2, 4);
            check("opcode", opcode, j ? OP_EXIT_4W : OP_RST_ENABLE);
            u_spi_master.deselect();
            if (j == 0) begin
                u_spi_master.select();
                send(OP_RESET, 2, 4);
                u_spi_master.deselect();
                check("soft_reset", 8'(n_rst - b), 8'h01);
            end
            check("four_wire_mode", 8'(four_wire_mode), 8'h00);
        end
        complete_run();
    end
endmodule
